// ---- fms_checker.sv ----
// Purpose: port-level assertions for the queue and modem status block
// Assumes: one clock, synchronous active-low reset
// Notes: state and filter outputs are registered, hence the short ranges
`default_nettype none
module fms_checker (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire fms_pkg::fms_req_t req_i,
   input wire fms_pkg::fms_evt_t evt_i,
   input wire logic strm_pop_i,
   input wire logic [7:0] rdata_o,
   input wire logic [7:0] strm_rdata_o,
   input wire logic irq_o,
   input wire logic filter_fast_o,
   input wire logic [2:0] state_o,
   input wire logic nearly_full_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);
   chk_flush_reads_zero: assert property (req_i.rd && req_i.addr == fms_pkg::OFF_LEVEL |=> !rdata_o[7])
      else $error("flush bit read back as one");
   chk_idle_rdata_zero: assert property (!req_i.rd |=> rdata_o == 8'h00)
      else $error("read data without a read strobe");
   chk_bus_fast: assert property (evt_i.bus_hs_proto |-> ##[1:2] filter_fast_o)
      else $error("fast filter not selected by protocol");
   chk_state_legal: assert property (state_o != 3'h7)
      else $error("illegal transceiver state code");
   chk_stop_idle: assert property (evt_i.cmd_stop && !evt_i.cmd_start |-> ##[1:2] state_o == fms_pkg::MS_IDLE)
      else $error("stop did not return to idle");
   chk_start_trig: assert property (state_o == fms_pkg::MS_IDLE && evt_i.cmd_start && !evt_i.cmd_stop
      |-> ##[1:2] state_o == fms_pkg::MS_TRIG)
      else $error("start did not reach trigger wait");
   chk_pop_hold: assert property (!strm_pop_i |=> $stable(strm_rdata_o))
      else $error("stream byte changed without a pop");
   chk_send_path: assert property ($changed(state_o) && state_o == fms_pkg::MS_SEND
      |-> $past(state_o) == fms_pkg::MS_TXW)
      else $error("sending not entered from tx wait");
   chk_data_path: assert property ($changed(state_o) && state_o == fms_pkg::MS_WDAT
      |-> $past(state_o) == fms_pkg::MS_RXW)
      else $error("data wait not entered from rx wait");
   cov_recv: cover property (state_o == fms_pkg::MS_RECV);
   cov_full: cover property (nearly_full_o);
   cov_irq: cover property (irq_o);
endmodule : fms_checker
bind fms_top fms_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req_i), .evt_i(evt_i),
   .strm_pop_i(strm_pop_i), .rdata_o(rdata_o), .strm_rdata_o(strm_rdata_o), .irq_o(irq_o),
   .filter_fast_o(filter_fast_o), .state_o(state_o), .nearly_full_o(nearly_full_o));
`default_nettype wire

// ---- fms_host.sv ----
// Purpose: host controller model on the register port
// Assumes: one-cycle strobes, read data in the cycle after the strobe
// Notes: each access leaves one idle cycle, which the port allows
`default_nettype none
module fms_host (
   input wire logic clk_i,
   input wire logic [7:0] rdata_i,
   output var fms_pkg::fms_req_t req_o
);
   timeunit 1ns;
   timeprecision 100ps;
   initial req_o = '0;
   // write strobe held for exactly one edge
   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge clk_i);
      req_o <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk_i);
      req_o <= '0;
      #1;
   endtask : wr
   // data are taken once the answering edge has settled
   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge clk_i);
      req_o <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_i);
      req_o <= '0;
      #1 v = rdata_i;
   endtask : rd
endmodule : fms_host
`default_nettype wire

// ---- fms_pkg.sv ----
// Purpose: constants and types of the queue and modem status block
// Assumes: 40 MHz clk_i, 8-bit register port
// Notes: offsets are byte addresses on the register port
`default_nettype none
package fms_pkg;
   localparam logic [7:0] OFF_ERR = 8'h06; // error flags
   localparam logic [7:0] OFF_STAT2 = 8'h08; // secondary status
   localparam logic [7:0] OFF_DATA = 8'h09; // queue data port
   localparam logic [7:0] OFF_LEVEL = 8'h0a; // fill level + flush
   localparam logic [7:0] OFF_THR = 8'h0b; // queue threshold
   localparam logic [7:0] OFF_FRAME = 8'h0d; // bit framing, bit 7 trigger
   localparam logic [7:0] OFF_IRQ = 8'h20; // sticky event status
   localparam logic [7:0] OFF_MASK = 8'h21; // event mask
   localparam logic [7:0] OFF_MCTL = 8'h22; // field-wait enables
   localparam logic [7:0] OFF_TXG = 8'h23; // tx guard time, cycles
   localparam logic [7:0] OFF_RXG = 8'h24; // rx guard time, cycles
   localparam int DEPTH = 64; // queue depth in bytes
   localparam logic [6:0] DEPTH_CNT = 7'h40; // depth at count width
   localparam logic [5:0] THR_RST = 6'h08; // threshold after reset
   localparam int B_FLUSH = 7; // level register flush bit
   localparam int B_TCLR = 7; // secondary status bits
   localparam int B_FAST = 6;
   localparam int B_TGT = 4;
   localparam int B_CIPH = 3;
   localparam int B_OVF = 4; // error register overflow bit
   localparam int B_TERR = 6; // error register temperature bit
   localparam int B_TRIG = 7; // framing register trigger bit
   localparam int N_EVT = 4; // interrupt event count
   // interrupt events: overflow, temperature, target, nearly full
   localparam int E_OVF = 0;
   localparam int E_TEMP = 1;
   localparam int E_TGT = 2;
   localparam int E_HI = 3;
   localparam logic [2:0] MS_IDLE = 3'h0; // transceiver state codes
   localparam logic [2:0] MS_TRIG = 3'h1;
   localparam logic [2:0] MS_TXW = 3'h2;
   localparam logic [2:0] MS_SEND = 3'h3;
   localparam logic [2:0] MS_RXW = 3'h4;
   localparam logic [2:0] MS_WDAT = 3'h5;
   localparam logic [2:0] MS_RECV = 3'h6;
   typedef enum {ST_IDLE, ST_TRIG, ST_TXW, ST_SEND, ST_RXW, ST_WDAT, ST_RECV} fms_state_t;
   // register port request
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } fms_req_t;
   // events from the rest of the frontend, same clock
   typedef struct packed {
      logic cmd_start; // transceive command begins
      logic cmd_stop; // command aborted or ended
      logic tx_done; // last bit sent
      logic rx_start; // first data seen
      logic rx_done; // frame received
      logic auto_coll; // anticollision command running
      logic passive; // passive communication mode
      logic sel_answered; // select or polling answered
      logic auth_ok; // card authentication succeeded
      logic reader_mode; // reader/writer mode
      logic bus_hs_proto; // serial bus runs high-speed protocol
   } fms_evt_t;
endpackage : fms_pkg
`default_nettype wire

// ---- fms_top.sv ----
// Purpose: 64-byte host queue, fill level, secondary status and modem state
// Assumes: one clock, synchronous active-low reset, same-clock frontend events
// Notes: register reads return data in the cycle after the read strobe
`default_nettype none
// Summary of operation
// [R01] temp clear works only below alarm limit
// [R02] force bit selects fast bus filter
// [R03] target flag set by answered select in anticollision; code also requires passive mode
// [R04] field off clears target flag
// [R05] cipher flag set by card authentication in reader mode
// [R06] software clears the cipher flag
// [R07] three-bit transceiver state code readable
// [R08] tx wait: field wait, tx guard time
// [R09] rx wait: field wait, rx guard time
// [R10] 64-byte queue behind one data port
// [R11] queue buffers serial streams too
// [R12] flush resets pointers, overflow; reads zero
// [R13] fill count tracks writes and reads
// [R14] nearly full when free space <= threshold
// [R15] nearly empty when count <= threshold
// [R16] write when full sets overflow, no store
// [R17] read when empty keeps count zero
module fms_top (
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire fms_pkg::fms_req_t req_i, // register port request
   input wire fms_pkg::fms_evt_t evt_i, // frontend events
   input wire logic temp_hot_i, // die above alarm limit, async pin
   input wire logic rf_field_i, // external field present, async pin
   input wire logic strm_push_i, // serial side pushes a byte
   input wire logic [7:0] strm_wdata_i, // byte pushed by serial side
   input wire logic strm_pop_i, // serial side pops a byte
   output logic [7:0] rdata_o, // register read data
   output logic [7:0] strm_rdata_o, // byte popped by serial side
   output logic irq_o, // level interrupt
   output logic filter_fast_o, // bus input filter in high-speed mode
   output logic [2:0] state_o, // transceiver state code
   output logic nearly_full_o,
   output logic nearly_empty_o
);
   // synchronisers for the two pins
   logic [1:0] hot_s_r, rf_s_r;
   logic rf_d_r; // delayed field for falling edge
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         hot_s_r <= 2'h0;
         rf_s_r <= 2'h0;
         rf_d_r <= 1'b0;
      end else begin
         hot_s_r <= {hot_s_r[0], temp_hot_i};
         rf_s_r <= {rf_s_r[0], rf_field_i};
         rf_d_r <= rf_s_r[1];
      end
   end
   logic hot, rf_on, rf_fall;
   assign hot = hot_s_r[1];
   assign rf_on = rf_s_r[1];
   assign rf_fall = rf_d_r & ~rf_on;

   // register port decode
   logic wr, rd;
   assign wr = req_i.wr;
   assign rd = req_i.rd;
   logic w_data, w_lvl, w_st2, r_data;
   assign w_data = wr && req_i.addr == fms_pkg::OFF_DATA;
   assign w_lvl = wr && req_i.addr == fms_pkg::OFF_LEVEL;
   assign w_st2 = wr && req_i.addr == fms_pkg::OFF_STAT2;
   assign r_data = rd && req_i.addr == fms_pkg::OFF_DATA;

   // ---------------- queue ----------------
   logic [7:0] mem_r [fms_pkg::DEPTH]; // flop storage
   logic [7:0] mem_nxt [fms_pkg::DEPTH];
   logic [5:0] wp_r, wp_nxt, rp_r, rp_nxt;
   logic [6:0] cnt_r, cnt_nxt;
   logic ovf_r, ovf_nxt;
   logic push, pop, host_pop, do_push, do_pop, ovf_evt;
   logic [7:0] push_data;
   // host owns the data port; a stream push during a host write, or a stream pop during a host read, is ignored
   assign push = w_data | (strm_push_i & ~w_data); // R11
   assign push_data = w_data ? req_i.wdata : strm_wdata_i; // R10
   assign host_pop = r_data;
   assign pop = r_data | (strm_pop_i & ~r_data); // R11
   assign do_pop = pop && cnt_r != 7'h00; // R17
   assign do_push = push && cnt_r != fms_pkg::DEPTH_CNT; // R16
   assign ovf_evt = push && cnt_r == fms_pkg::DEPTH_CNT; // R16

   // next pointers, count and overflow flag
   always_comb begin
      wp_nxt = wp_r;
      rp_nxt = rp_r;
      cnt_nxt = cnt_r;
      ovf_nxt = ovf_r | ovf_evt;
      mem_nxt = mem_r;
      if (w_lvl && req_i.wdata[fms_pkg::B_FLUSH]) begin
         // flush wins over a simultaneous data access
         wp_nxt = 6'h00; // R12
         rp_nxt = 6'h00; // R12
         cnt_nxt = 7'h00; // R12
         ovf_nxt = 1'b0; // R12
      end else begin
         if (do_push) begin
            mem_nxt[wp_r] = push_data; // R10
            wp_nxt = wp_r + 6'h01; // six-bit wrap is the 64-entry ring
         end
         if (do_pop) begin
            rp_nxt = rp_r + 6'h01;
         end
         // R13
         case ({do_push, do_pop})
            2'b10: cnt_nxt = cnt_r + 7'h01;
            2'b01: cnt_nxt = cnt_r - 7'h01;
            default: cnt_nxt = cnt_r;
         endcase
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         wp_r <= 6'h00;
         rp_r <= 6'h00;
         cnt_r <= 7'h00;
         ovf_r <= 1'b0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
         cnt_r <= cnt_nxt;
         ovf_r <= ovf_nxt;
      end
   end
   // storage has no reset; contents are undefined until written
   always_ff @(posedge clk_i) begin
      mem_r <= mem_nxt;
   end

   // ---------------- control and status bits ----------------
   logic [5:0] thr_r, thr_nxt;
   logic terr_r, terr_nxt; // latched temperature error
   logic tclr_r, tclr_nxt; // stored clear bit
   logic fast_r, fast_nxt; // force fast filter
   logic tgt_r, tgt_nxt;
   logic ciph_r, ciph_nxt;
   logic [1:0] mctl_r, mctl_nxt; // bit0 tx field wait, bit1 rx field wait
   logic [7:0] txg_r, txg_nxt, rxg_r, rxg_nxt;
   logic [fms_pkg::N_EVT-1:0] ists_r, ists_nxt, imsk_r, imsk_nxt;
   logic hi_r, hi_nxt, lo_r, lo_nxt, filt_r, filt_nxt;
   logic tgt_set, hi_rise;
   logic [fms_pkg::N_EVT-1:0] evt_v;
   logic [6:0] free_cnt;
   assign tgt_set = evt_i.sel_answered & evt_i.auto_coll & evt_i.passive; // R03
   assign free_cnt = fms_pkg::DEPTH_CNT - cnt_nxt;
   assign hi_rise = hi_nxt & ~hi_r;
   always_comb begin
      evt_v = '0;
      evt_v[fms_pkg::E_OVF] = ovf_evt;
      evt_v[fms_pkg::E_TEMP] = hot & ~terr_r;
      evt_v[fms_pkg::E_TGT] = tgt_set & ~tgt_r;
      evt_v[fms_pkg::E_HI] = hi_rise;
   end

   // next values of control, flags and interrupt registers
   always_comb begin
      thr_nxt = thr_r;
      tclr_nxt = tclr_r;
      fast_nxt = fast_r;
      ciph_nxt = ciph_r;
      mctl_nxt = mctl_r;
      txg_nxt = txg_r;
      rxg_nxt = rxg_r;
      imsk_nxt = imsk_r;
      terr_nxt = terr_r;
      tgt_nxt = tgt_r;
      if (wr) begin
         case (req_i.addr)
            fms_pkg::OFF_THR: thr_nxt = req_i.wdata[5:0];
            fms_pkg::OFF_MCTL: mctl_nxt = req_i.wdata[1:0];
            fms_pkg::OFF_TXG: txg_nxt = req_i.wdata;
            fms_pkg::OFF_RXG: rxg_nxt = req_i.wdata;
            fms_pkg::OFF_MASK: imsk_nxt = req_i.wdata[fms_pkg::N_EVT-1:0];
            fms_pkg::OFF_STAT2: begin
               tclr_nxt = req_i.wdata[fms_pkg::B_TCLR];
               fast_nxt = req_i.wdata[fms_pkg::B_FAST]; // R02
               ciph_nxt = req_i.wdata[fms_pkg::B_CIPH]; // R06
            end
            default: begin
            end
         endcase
      end
      // clear only while cool; a hot sample keeps it set
      if (w_st2 && req_i.wdata[fms_pkg::B_TCLR] && !hot) begin
         terr_nxt = 1'b0; // R01
      end
      if (hot) begin
         terr_nxt = 1'b1;
      end
      if (rf_fall) begin
         tgt_nxt = 1'b0; // R04
      end
      if (tgt_set) begin
         tgt_nxt = 1'b1; // R03
      end
      // authentication beats a software clear in the same cycle
      if (evt_i.auth_ok && evt_i.reader_mode) begin
         ciph_nxt = 1'b1; // R05
      end
      // write-one-to-clear, a new event wins
      ists_nxt = ists_r;
      if (wr && req_i.addr == fms_pkg::OFF_IRQ) begin
         ists_nxt = ists_r & ~req_i.wdata[fms_pkg::N_EVT-1:0];
      end
      ists_nxt = ists_nxt | evt_v;
      hi_nxt = free_cnt <= {1'b0, thr_nxt}; // R14
      lo_nxt = cnt_nxt <= {1'b0, thr_nxt}; // R15
      filt_nxt = fast_nxt | evt_i.bus_hs_proto; // R02
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         thr_r <= fms_pkg::THR_RST;
         terr_r <= 1'b0;
         tclr_r <= 1'b0;
         fast_r <= 1'b0;
         tgt_r <= 1'b0;
         ciph_r <= 1'b0;
         mctl_r <= 2'h0;
         txg_r <= 8'h00;
         rxg_r <= 8'h00;
         ists_r <= '0;
         imsk_r <= '0;
         hi_r <= 1'b0;
         lo_r <= 1'b1;
         filt_r <= 1'b0;
      end else begin
         thr_r <= thr_nxt;
         terr_r <= terr_nxt;
         tclr_r <= tclr_nxt;
         fast_r <= fast_nxt;
         tgt_r <= tgt_nxt;
         ciph_r <= ciph_nxt;
         mctl_r <= mctl_nxt;
         txg_r <= txg_nxt;
         rxg_r <= rxg_nxt;
         ists_r <= ists_nxt;
         imsk_r <= imsk_nxt;
         hi_r <= hi_nxt;
         lo_r <= lo_nxt;
         filt_r <= filt_nxt;
      end
   end

   // ---------------- transceiver state machine ----------------
   fms_pkg::fms_state_t st_r, st_nxt;
   logic [7:0] gcnt_r, gcnt_nxt; // cycles spent in a wait state
   logic trig;
   assign trig = wr && req_i.addr == fms_pkg::OFF_FRAME && req_i.wdata[fms_pkg::B_TRIG];
   always_comb begin
      st_nxt = st_r;
      gcnt_nxt = 8'h00;
      case (st_r)
         fms_pkg::ST_IDLE: if (evt_i.cmd_start) st_nxt = fms_pkg::ST_TRIG;
         fms_pkg::ST_TRIG: if (trig) st_nxt = fms_pkg::ST_TXW;
         fms_pkg::ST_TXW: begin
            // go to sending only after guard time and, if asked, with field
            gcnt_nxt = (gcnt_r == 8'hff) ? gcnt_r : gcnt_r + 8'h01;
            if (gcnt_r >= txg_r && (rf_on || !mctl_r[0])) begin
               st_nxt = fms_pkg::ST_SEND; // R08
            end
         end
         fms_pkg::ST_SEND: if (evt_i.tx_done) st_nxt = fms_pkg::ST_RXW;
         fms_pkg::ST_RXW: begin
            gcnt_nxt = (gcnt_r == 8'hff) ? gcnt_r : gcnt_r + 8'h01;
            if (gcnt_r >= rxg_r && (rf_on || !mctl_r[1])) begin
               st_nxt = fms_pkg::ST_WDAT; // R09
            end
         end
         fms_pkg::ST_WDAT: if (evt_i.rx_start) st_nxt = fms_pkg::ST_RECV;
         fms_pkg::ST_RECV: if (evt_i.rx_done) st_nxt = fms_pkg::ST_IDLE;
         default: st_nxt = fms_pkg::ST_IDLE;
      endcase
      if (evt_i.cmd_stop) begin
         st_nxt = fms_pkg::ST_IDLE;
      end
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         st_r <= fms_pkg::ST_IDLE;
         gcnt_r <= 8'h00;
      end else begin
         st_r <= st_nxt;
         gcnt_r <= gcnt_nxt;
      end
   end
   logic [2:0] code, code_nxt;
   always_comb begin
      case (st_nxt)
         fms_pkg::ST_TRIG: code_nxt = fms_pkg::MS_TRIG; // R07
         fms_pkg::ST_TXW: code_nxt = fms_pkg::MS_TXW;
         fms_pkg::ST_SEND: code_nxt = fms_pkg::MS_SEND;
         fms_pkg::ST_RXW: code_nxt = fms_pkg::MS_RXW;
         fms_pkg::ST_WDAT: code_nxt = fms_pkg::MS_WDAT;
         fms_pkg::ST_RECV: code_nxt = fms_pkg::MS_RECV;
         default: code_nxt = fms_pkg::MS_IDLE;
      endcase
   end

   // ---------------- read data and outputs ----------------
   logic [7:0] rdata_nxt, srd_nxt;
   logic irq_nxt;
   always_comb begin
      rdata_nxt = 8'h00; // unmapped addresses read zero
      if (rd) begin
         case (req_i.addr)
            fms_pkg::OFF_DATA: rdata_nxt = mem_r[rp_r]; // R10
            fms_pkg::OFF_LEVEL: rdata_nxt = {1'b0, cnt_r}; // R12 R13
            fms_pkg::OFF_STAT2: rdata_nxt = {tclr_r, fast_r, 1'b0, tgt_r, ciph_r, code}; // R07
            fms_pkg::OFF_THR: rdata_nxt = {2'h0, thr_r};
            fms_pkg::OFF_ERR: rdata_nxt = {1'b0, terr_r, 1'b0, ovf_r, 4'h0};
            fms_pkg::OFF_IRQ: rdata_nxt = {4'h0, ists_r};
            fms_pkg::OFF_MASK: rdata_nxt = {4'h0, imsk_r};
            fms_pkg::OFF_MCTL: rdata_nxt = {6'h00, mctl_r};
            fms_pkg::OFF_TXG: rdata_nxt = txg_r;
            fms_pkg::OFF_RXG: rdata_nxt = rxg_r;
            default: rdata_nxt = 8'h00;
         endcase
      end
      // stream pop sees the head byte; host pops win the port
      srd_nxt = (strm_pop_i && !host_pop) ? mem_r[rp_r] : strm_rdata_o;
      irq_nxt = |(ists_nxt & imsk_nxt);
   end
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_o <= 8'h00;
         strm_rdata_o <= 8'h00;
         irq_o <= 1'b0;
         code <= fms_pkg::MS_IDLE;
      end else begin
         rdata_o <= rdata_nxt;
         strm_rdata_o <= srd_nxt;
         irq_o <= irq_nxt;
         code <= code_nxt;
      end
   end
   assign state_o = code;
   assign filter_fast_o = filt_r;
   assign nearly_full_o = hi_r;
   assign nearly_empty_o = lo_r;
endmodule : fms_top
`default_nettype wire

// ---- test_fms_top.sv ----
// Purpose: self-checking bench for the queue and modem status block
// Assumes: host model drives the register port, bench drives the rest
// Notes: guard times kept short so the run stays brief
`default_nettype none
module test_fms_top;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   fms_pkg::fms_req_t req;
   fms_pkg::fms_evt_t evt = '0;
   logic hot = 1'b0;
   logic rf = 1'b1;
   logic push = 1'b0;
   logic pop = 1'b0;
   logic [7:0] sdat = 8'h00;
   logic [7:0] rdata, srd, d;
   logic irq, fast, nf, ne;
   logic [2:0] st;
   int err_count = 0;
   int tests_run = 0;
   int n;
   fms_top u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .req_i(req), .evt_i(evt), .temp_hot_i(hot),
      .rf_field_i(rf), .strm_push_i(push), .strm_wdata_i(sdat), .strm_pop_i(pop), .rdata_o(rdata),
      .strm_rdata_o(srd), .irq_o(irq), .filter_fast_o(fast), .state_o(st), .nearly_full_o(nf),
      .nearly_empty_o(ne));
   fms_host u_host (.clk_i(clk_i), .rdata_i(rdata), .req_o(req));
   initial begin
      forever #12.5 clk_i = ~clk_i;
   end
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask : cmp
   // masked register read against an expected value
   task automatic rdc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      u_host.rd(a, d);
      cmp(d & m, e);
   endtask : rdc
   // one-cycle pulse on selected event lines
   task automatic pulse(input logic [10:0] m);
      @(posedge clk_i);
      evt <= evt | m;
      @(posedge clk_i);
      evt <= evt & ~m;
      #1;
   endtask : pulse
   // bounded wait for a state code; n counts the cycles spent
   task automatic wait_st(input logic [2:0] c);
      n = 0;
      while (st !== c && n < 60) begin
         @(posedge clk_i);
         #1 n++;
      end
      cmp({5'h0, st}, {5'h0, c});
   endtask : wait_st
   task automatic t_reset;
      rdc(fms_pkg::OFF_LEVEL, 8'hff, 8'h00);
      rdc(fms_pkg::OFF_THR, 8'h3f, {2'b00, fms_pkg::THR_RST});
      cmp({7'h0, ne}, 8'h01);
   endtask : t_reset
   // order kept, count follows, empty read leaves count at zero
   task automatic t_queue;
      for (int i = 0; i < 3; i++)
         u_host.wr(fms_pkg::OFF_DATA, 8'ha0 + i[7:0]);
      rdc(fms_pkg::OFF_LEVEL, 8'hff, 8'h03);
      for (int i = 0; i < 3; i++)
         rdc(fms_pkg::OFF_DATA, 8'hff, 8'ha0 + i[7:0]);
      u_host.rd(fms_pkg::OFF_DATA, d);
      rdc(fms_pkg::OFF_LEVEL, 8'hff, 8'h00);
   endtask : t_queue
   // fill to refusal, overflow interrupt, flush
   task automatic t_full;
      u_host.wr(fms_pkg::OFF_MASK, 8'h01);
      for (int i = 1; i <= fms_pkg::DEPTH; i++) begin
         u_host.wr(fms_pkg::OFF_DATA, i[7:0]);
         if (i == 55 || i == 56)
            cmp({7'h0, nf}, {7'h0, i == 56});
      end
      cmp({7'h0, ne}, 8'h00);
      u_host.wr(fms_pkg::OFF_DATA, 8'hee);
      rdc(fms_pkg::OFF_ERR, 8'h10, 8'h10);
      rdc(fms_pkg::OFF_LEVEL, 8'hff, {1'b0, fms_pkg::DEPTH_CNT});
      cmp({7'h0, irq}, 8'h01);
      u_host.wr(fms_pkg::OFF_LEVEL, 8'h80);
      rdc(fms_pkg::OFF_LEVEL, 8'hff, 8'h00);
      rdc(fms_pkg::OFF_ERR, 8'h10, 8'h00);
      u_host.wr(fms_pkg::OFF_IRQ, 8'h01);
      rdc(fms_pkg::OFF_IRQ, 8'h01, 8'h00);
      cmp({7'h0, irq}, 8'h00);
   endtask : t_full
   // serial side shares the queue with the host port
   task automatic t_stream;
      @(posedge clk_i);
      push <= 1'b1;
      sdat <= 8'h55;
      @(posedge clk_i);
      push <= 1'b0;
      rdc(fms_pkg::OFF_DATA, 8'hff, 8'h55);
      u_host.wr(fms_pkg::OFF_DATA, 8'h3c);
      @(posedge clk_i);
      pop <= 1'b1;
      @(posedge clk_i);
      pop <= 1'b0;
      #1 cmp(srd, 8'h3c);
   endtask : t_stream
   task automatic t_modem;
      u_host.wr(fms_pkg::OFF_TXG, 8'h04);
      u_host.wr(fms_pkg::OFF_RXG, 8'h02);
      u_host.wr(fms_pkg::OFF_MCTL, 8'h02);
      pulse(11'h400);
      wait_st(fms_pkg::MS_TRIG);
      rdc(fms_pkg::OFF_STAT2, 8'h07, {5'h0, fms_pkg::MS_TRIG});
      u_host.wr(fms_pkg::OFF_FRAME, 8'h80);
      wait_st(fms_pkg::MS_TXW);
      wait_st(fms_pkg::MS_SEND);
      cmp({7'h0, n >= 4}, 8'h01);
      @(posedge clk_i);
      rf <= 1'b0;
      pulse(11'h100);
      wait_st(fms_pkg::MS_RXW);
      repeat (20) @(posedge clk_i);
      #1 cmp({5'h0, st}, {5'h0, fms_pkg::MS_RXW});
      rf <= 1'b1;
      wait_st(fms_pkg::MS_WDAT);
      pulse(11'h080);
      wait_st(fms_pkg::MS_RECV);
      pulse(11'h040);
      wait_st(fms_pkg::MS_IDLE);
      pulse(11'h400);
      wait_st(fms_pkg::MS_TRIG);
      pulse(11'h200);
      wait_st(fms_pkg::MS_IDLE);
      // tx field wait: guard time long over, still held until the field returns
      u_host.wr(fms_pkg::OFF_MCTL, 8'h01);
      @(posedge clk_i);
      rf <= 1'b0;
      pulse(11'h400);
      u_host.wr(fms_pkg::OFF_FRAME, 8'h80);
      repeat (20) @(posedge clk_i);
      #1 cmp({5'h0, st}, {5'h0, fms_pkg::MS_TXW});
      rf <= 1'b1;
      wait_st(fms_pkg::MS_SEND);
      pulse(11'h200);
      wait_st(fms_pkg::MS_IDLE);
   endtask : t_modem
   task automatic t_status;
      u_host.wr(fms_pkg::OFF_STAT2, 8'h40);
      rdc(fms_pkg::OFF_STAT2, 8'h40, 8'h40);
      cmp({7'h0, fast}, 8'h01);
      u_host.wr(fms_pkg::OFF_STAT2, 8'h00);
      rdc(fms_pkg::OFF_STAT2, 8'h40, 8'h00);
      cmp({7'h0, fast}, 8'h00);
      // force bit clear: the filter follows the protocol in use
      evt.bus_hs_proto <= 1'b1;
      repeat (2) @(posedge clk_i);
      #1 cmp({7'h0, fast}, 8'h01);
      evt.bus_hs_proto <= 1'b0;
      @(posedge clk_i);
      hot <= 1'b1;
      repeat (4) @(posedge clk_i);
      u_host.wr(fms_pkg::OFF_STAT2, 8'h80);
      rdc(fms_pkg::OFF_ERR, 8'h40, 8'h40);
      hot <= 1'b0;
      repeat (4) @(posedge clk_i);
      u_host.wr(fms_pkg::OFF_STAT2, 8'h80);
      rdc(fms_pkg::OFF_ERR, 8'h40, 8'h00);
      pulse(11'h008);
      rdc(fms_pkg::OFF_STAT2, 8'h10, 8'h00);
      evt.auto_coll <= 1'b1;
      evt.passive <= 1'b1;
      pulse(11'h008);
      rdc(fms_pkg::OFF_STAT2, 8'h10, 8'h10);
      rf <= 1'b0;
      repeat (4) @(posedge clk_i);
      rdc(fms_pkg::OFF_STAT2, 8'h10, 8'h00);
      rf <= 1'b1;
      evt.reader_mode <= 1'b1;
      pulse(11'h004);
      repeat (5) @(posedge clk_i);
      rdc(fms_pkg::OFF_STAT2, 8'h08, 8'h08);
      u_host.wr(fms_pkg::OFF_STAT2, 8'h00);
      rdc(fms_pkg::OFF_STAT2, 8'h08, 8'h00);
   endtask : t_status
   task automatic tally_and_finish;
      if (err_count == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask : tally_and_finish
   // main sequence, all requests start after reset is released
   initial begin
      repeat (4) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      t_reset();
      t_queue();
      t_full();
      t_stream();
      t_modem();
      t_status();
      tally_and_finish();
   end
   // the whole run needs well under 2000 cycles
   initial begin
      #200us;
      err_count++;
      tally_and_finish();
   end
endmodule : test_fms_top
`default_nettype wire
